// ===== inc/ssp_pkg.sv
/*
  Constants of the status and write-protect block of a serial EEPROM:
  opcodes, status bit positions, protected-region bounds and timing.
  Assumes a 10 MHz system clock and an SPI host running mode 0.
*/
package ssp_pkg;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OP_SET_LATCH   = 8'h06;
  localparam logic [7:0] OP_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STAT  = 8'h01;

  // ****************************************************************
  // Status byte layout
  // ****************************************************************
  localparam int          BIT_LOCK      = 7;
  localparam int          BIT_SEL_HI    = 3;
  localparam int          BIT_SEL_LO    = 2;
  localparam int          BIT_LATCH     = 1;
  localparam int          BIT_BUSY      = 0;
  localparam logic        LOCK_RESET    = 1'b0;
  localparam logic [1:0]  SEL_RESET     = 2'b00;

  // ****************************************************************
  // Array and protected regions
  // ****************************************************************
  localparam int          ADDR_W        = 11;
  localparam logic [10:0] ADDR_QUARTER  = 11'h600;
  localparam logic [10:0] ADDR_HALF     = 11'h400;
  localparam logic [10:0] ADDR_TOP      = 11'h7FF;
  localparam logic [1:0]  SEL_NONE      = 2'b00;
  localparam logic [1:0]  SEL_QUARTER   = 2'b01;
  localparam logic [1:0]  SEL_HALF      = 2'b10;
  localparam logic [1:0]  SEL_WHOLE     = 2'b11;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 100;
  localparam int          WRITE_TIME_US = 5000;
  localparam logic [2:0]  LAST_BIT      = 3'h7;

  typedef enum logic [1:0] {
    SSP_WR_NONE,
    SSP_WR_STATUS,
    SSP_WR_ARRAY
  } ssp_wr_kind_t;

endpackage

// ===== inc/ssp_spi_if.sv
/*
  Carrier between the SPI front end and the status core: synchronised
  pin levels and one-cycle edge events. Assumes one system clock.
*/
`timescale 1ns/1ps
interface ssp_spi_if;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic cs_rise;
  logic mosi;
  logic wp_n;

  modport front (output sck_rise, sck_fall, cs_fall, cs_rise, mosi, wp_n);
  modport core  (input  sck_rise, sck_fall, cs_fall, cs_rise, mosi, wp_n);
endinterface

// ===== rtl/ssp_spi_front.sv
/*
  Two-flop synchronisers for the SPI pins and write-protect pin, with
  edge detection on the synchronised clock and chip select.
  Assumes pins are asynchronous to clk_sys_in and slow against it.
*/
`timescale 1ns/1ps
module ssp_spi_front (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic sck_in,
  input  wire logic csn_in,
  input  wire logic mosi_in,
  input  wire logic wp_n_in,
  ssp_spi_if.front  link
);
  import ssp_pkg::*;

  logic [3:0] meta_q;
  logic [3:0] sync_q;
  logic       sck_prev_q;
  logic       csn_prev_q;

  // ****************************************************************
  // Synchronisers; chip select starts high so a falling edge is needed
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= 4'b1110;
      sync_q <= 4'b1110;
    end else begin
      meta_q <= {wp_n_in, csn_in, mosi_in, sck_in};
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sck_prev_q <= 1'b0;
      csn_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sync_q[0];
      csn_prev_q <= sync_q[2];
    end
  end

  assign link.sck_rise = sync_q[0] & ~sck_prev_q & ~sync_q[2];
  assign link.sck_fall = ~sync_q[0] & sck_prev_q & ~sync_q[2];
  assign link.cs_fall  = ~sync_q[2] & csn_prev_q;
  assign link.cs_rise  = sync_q[2] & ~csn_prev_q;
  assign link.mosi     = sync_q[1];
  assign link.wp_n     = sync_q[3];
endmodule

// ===== rtl/ssp_write_timer.sv
/*
  Self-timed write cycle counter: a start pulse begins a cycle of
  CYCLES clocks; busy stands meanwhile and done marks its last cycle.
  Assumes start is never raised while busy.
*/
`timescale 1ns/1ps
module ssp_write_timer #(
  parameter int CYCLES = 50000
) (
  input  wire logic clk_sys_in,
  input  wire logic resetn_in,
  input  wire logic start_in,
  output logic      busy_out,
  output logic      done_out
);
  localparam int CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_q;

  // Done stands in the last busy cycle so that what it commits changes
  // on the same edge as busy falls
  assign done_out = busy_out && (cnt_q == CNT_LAST);

  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q    <= '0;
      busy_out <= 1'b0;
    end else if (start_in && !busy_out) begin
      busy_out <= 1'b1;
      cnt_q    <= '0;
    end else if (busy_out) begin
      if (cnt_q == CNT_LAST) begin
        busy_out <= 1'b0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// ===== rtl/ssp_status_protect.sv
/*
  Status register and write protection of a serial EEPROM: latch set
  and clear, status read and write over SPI, self-timed write cycle,
  block protection and hardware-protected mode. Memory array writes
  arrive as requests from array logic on the same clock.
  Assumes SPI mode 0 and a host that keeps SCK well below clk_sys_in/4.
*/
`timescale 1ns/1ps
module ssp_status_protect #(
  parameter int WRITE_CYCLES = ssp_pkg::WRITE_TIME_US * 1000 / ssp_pkg::CLK_PERIOD_NS
) (
  input  wire logic                      clk_sys_in,
  input  wire logic                      resetn_in,
  input  wire logic                      spi_sck_in,
  input  wire logic                      spi_csn_in,
  input  wire logic                      spi_mosi_in,
  output logic                           spi_miso_out,
  output logic                           spi_miso_oen_n_out,
  input  wire logic                      wp_n_in,
  input  wire logic                      mem_wr_req_in,
  input  wire logic [ssp_pkg::ADDR_W-1:0] mem_wr_addr_in,
  output logic                           mem_wr_accept_out,
  output logic                           mem_wr_reject_out,
  output logic                           write_latch_flag_out,
  output logic                           write_busy_flag_out,
  output logic [1:0]                     protect_sel_out,
  output logic                           hw_protected_mode_out
);
  import ssp_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_OPCODE,
    ST_WAIT,
    ST_STATUS_RD,
    ST_STATUS_DATA,
    ST_IGNORE
  } ssp_state_t;

  ssp_spi_if link ();

  ssp_state_t   state_q;
  logic [7:0]   shift_q;
  logic [2:0]   bit_cnt_q;
  logic [7:0]   opcode_q;
  logic         byte_done_q;
  logic [2:0]   rd_idx_q;
  logic [6:0]   rd_shift_q;

  // Status bits, pending values and write cycle kind
  logic         latch_q;
  logic         lock_q;
  logic [1:0]   sel_q;
  logic         pend_lock_q;
  logic [1:0]   pend_sel_q;
  ssp_wr_kind_t kind_q;
  logic         hpm_q;
  logic         busy;
  logic         done;
  logic         hw_protected_mode;
  logic         stat_start;
  logic         mem_ok;
  logic         latch_cmd;
  logic         timer_start;
  logic [7:0]   status;
  logic [7:0]   in_byte;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Protected regions all end at the top of the array
  function automatic logic in_region(input logic [1:0] sel, input logic [ADDR_W-1:0] a);
    unique case (sel)
      SEL_NONE:    in_region = 1'b0;
      SEL_QUARTER: in_region = (a >= ADDR_QUARTER) && (a <= ADDR_TOP);
      SEL_HALF:    in_region = (a >= ADDR_HALF) && (a <= ADDR_TOP);
      SEL_WHOLE:   in_region = 1'b1;
    endcase
  endfunction

  function automatic logic [7:0] pack_status(input logic lk, input logic [1:0] sl,
                                             input logic la, input logic bz);
    logic [7:0] s;
    // Reserved bits b6 to b4 stay zero
    s = '0;
    s[BIT_LOCK]   = lk;
    s[BIT_SEL_HI] = sl[1];
    s[BIT_SEL_LO] = sl[0];
    s[BIT_LATCH]  = la;
    s[BIT_BUSY]   = bz;
    pack_status = s;
  endfunction

  // ****************************************************************
  // Front end and write timer
  // ****************************************************************
  // Pins pass two flops here; edge events last one cycle
  ssp_spi_front u_front (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .sck_in     (spi_sck_in),
    .csn_in     (spi_csn_in),
    .mosi_in    (spi_mosi_in),
    .wp_n_in    (wp_n_in),
    .link       (link.front)
  );

  // Done stands in the last busy cycle, so commits meet the fall of busy
  ssp_write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .clk_sys_in (clk_sys_in),
    .resetn_in  (resetn_in),
    .start_in   (timer_start),
    .busy_out   (busy),
    .done_out   (done)
  );

  // ****************************************************************
  // Decisions
  // ****************************************************************
  assign hw_protected_mode     = lock_q & ~link.wp_n;
  assign status  = pack_status(lock_q, sel_q, latch_q, busy);
  assign in_byte = {shift_q[6:0], link.mosi};

  // Status write starts only on a clean byte boundary with the latch set
  assign stat_start = link.cs_rise && (state_q == ST_STATUS_DATA) && byte_done_q
                      && latch_q && !busy
                      && !hw_protected_mode;
  // Array writes need the latch, an idle timer and an open region
  assign mem_ok      = mem_wr_req_in && latch_q && !busy
                       && !in_region(sel_q, mem_wr_addr_in);
  assign timer_start = stat_start | (mem_ok & ~stat_start);

  // Set or clear command complete: whole opcode byte, no extra clocks
  assign latch_cmd   = link.cs_rise && (state_q == ST_WAIT) && byte_done_q && !busy;

  // ****************************************************************
  // Command sequencer
  // ****************************************************************
  // Deselect wins over any clock edge; other blocks act on the state
  // that the frame left, read in the same cycle as the deselect
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q     <= ST_IDLE;
      shift_q     <= '0;
      bit_cnt_q   <= '0;
      opcode_q    <= '0;
      byte_done_q <= 1'b0;
    end else if (link.cs_rise) begin
      state_q     <= ST_IDLE;
      byte_done_q <= 1'b0;
    end else if (link.cs_fall) begin
      state_q     <= ST_OPCODE;
      bit_cnt_q   <= '0;
      byte_done_q <= 1'b0;
    end else if (link.sck_rise) begin
      unique case (state_q)
        ST_OPCODE: begin
          shift_q   <= in_byte;
          bit_cnt_q <= bit_cnt_q + 1'b1;
          if (bit_cnt_q == LAST_BIT) begin
            opcode_q    <= in_byte;
            byte_done_q <= 1'b1;
            // Unknown opcodes, array reads and writes included, are ignored
            unique case (in_byte)
              OP_SET_LATCH, OP_CLEAR_LATCH: state_q <= ST_WAIT;
              OP_READ_STATUS:               state_q <= ST_STATUS_RD;
              OP_WRITE_STAT: begin
                state_q     <= ST_STATUS_DATA;
                byte_done_q <= 1'b0;
              end
              default:                      state_q <= ST_IGNORE;
            endcase
          end
        end
        ST_STATUS_DATA: begin
          shift_q   <= in_byte;
          bit_cnt_q <= bit_cnt_q + 1'b1;
          // A clock after the eighth data bit spoils the byte boundary
          if (byte_done_q) begin
            state_q     <= ST_IGNORE;
            byte_done_q <= 1'b0;
          end else if (bit_cnt_q == LAST_BIT) begin
            byte_done_q <= 1'b1;
          end
        end
        ST_WAIT: begin
          state_q     <= ST_IGNORE;
          byte_done_q <= 1'b0;
        end
        ST_IDLE, ST_STATUS_RD, ST_IGNORE: begin
        end
      endcase
    end
  end

  // ****************************************************************
  // Status shift-out, repeated per byte while selected
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_idx_q           <= '0;
      rd_shift_q         <= '0;
      spi_miso_out       <= 1'b0;
      spi_miso_oen_n_out <= 1'b1;
    end else if (link.cs_rise || link.cs_fall) begin
      rd_idx_q           <= '0;
      spi_miso_oen_n_out <= 1'b1;
    // Each byte start re-samples the status, so polling sees fresh bits
    end else if (link.sck_fall && state_q == ST_STATUS_RD) begin
      spi_miso_oen_n_out <= 1'b0;
      rd_idx_q           <= rd_idx_q + 1'b1;
      if (rd_idx_q == '0) begin
        spi_miso_out <= status[7];
        rd_shift_q   <= status[6:0];
      end else begin
        spi_miso_out <= rd_shift_q[6];
        rd_shift_q   <= {rd_shift_q[5:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // Write-enable latch
  // ****************************************************************
  // Set and clear wait for deselect and are refused while a write cycle
  // runs, so they never meet done in the same cycle
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      latch_q <= 1'b0;
    end else if (done) begin
      latch_q <= 1'b0;
    end else if (latch_cmd) begin
      if (opcode_q == OP_SET_LATCH) begin
        latch_q <= 1'b1;
      end else begin
        latch_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Pending protect values and kind of the running write cycle
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_lock_q <= LOCK_RESET;
      pend_sel_q  <= SEL_RESET;
      kind_q      <= SSP_WR_NONE;
    end else if (stat_start) begin
      pend_lock_q <= shift_q[BIT_LOCK];
      pend_sel_q  <= {shift_q[BIT_SEL_HI], shift_q[BIT_SEL_LO]};
      kind_q      <= SSP_WR_STATUS;
    end else if (mem_ok) begin
      kind_q <= SSP_WR_ARRAY;
    end else if (done) begin
      kind_q <= SSP_WR_NONE;
    end
  end

  // ****************************************************************
  // Non-volatile protect bits, committed only as a status cycle ends
  // ****************************************************************
  // Old values stay visible to reads and to array writes until then
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      lock_q <= LOCK_RESET;
      sel_q  <= SEL_RESET;
    end else if (done && kind_q == SSP_WR_STATUS) begin
      lock_q <= pend_lock_q;
      sel_q  <= pend_sel_q;
    end
  end

  // ****************************************************************
  // Array write answer, one cycle after the request
  // ****************************************************************
  // A status write starting in the same cycle takes the timer first
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mem_wr_accept_out <= 1'b0;
      mem_wr_reject_out <= 1'b0;
    end else begin
      mem_wr_accept_out <= mem_ok & ~stat_start;
      mem_wr_reject_out <= mem_wr_req_in & ~(mem_ok & ~stat_start);
    end
  end

  // ****************************************************************
  // Protected mode flag
  // ****************************************************************
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      hpm_q <= 1'b0;
    end else begin
      hpm_q <= hw_protected_mode;
    end
  end

  assign write_latch_flag_out  = latch_q;
  assign write_busy_flag_out   = busy;
  assign protect_sel_out       = sel_q;
  assign hw_protected_mode_out = hpm_q;
endmodule

// ===== verification/ssp_spi_host.sv
/* SPI host model in mode 0 for the status block.
   Assumes the bench calls xfer just after a system clock edge. */
`timescale 1ns/1ps
module ssp_spi_host (
  output logic     sck_out,
  output logic     csn_out,
  output logic     mosi_out,
  input  wire logic miso_in
);
  initial begin
    sck_out = 1'b0;
    csn_out = 1'b1;
    mosi_out = 1'b0;
  end
  // ****************************************************************
  // One frame: opcode byte first, MSB first, clock idle low
  // ****************************************************************
  task automatic xfer(input logic [23:0] bits, input int n, output logic [15:0] rd);
    rd = '0;
    csn_out = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi_out = bits[23-i];
      #400 sck_out = 1'b1;
      #400 rd = {rd[14:0], miso_in};
      sck_out = 1'b0;
    end
    #200 csn_out = 1'b1;
    mosi_out = ~mosi_out;
    #1000;
  endtask
endmodule

// ===== verification/ssp_status_protect_checker.sv
/* Port checks of ssp_status_protect.
   Assumes one clock domain; bound with the design's WRITE_CYCLES. */
`timescale 1ns/1ps
module ssp_status_protect_checker
  import ssp_pkg::*;
#(
  parameter int WRITE_CYCLES = 50000
) (
  input wire logic              clk_sys_in,
  input wire logic              resetn_in,
  input wire logic              spi_sck_in,
  input wire logic              spi_csn_in,
  input wire logic              spi_mosi_in,
  input wire logic              spi_miso_out,
  input wire logic              spi_miso_oen_n_out,
  input wire logic              wp_n_in,
  input wire logic              mem_wr_req_in,
  input wire logic [ADDR_W-1:0] mem_wr_addr_in,
  input wire logic              mem_wr_accept_out,
  input wire logic              mem_wr_reject_out,
  input wire logic              write_latch_flag_out,
  input wire logic              write_busy_flag_out,
  input wire logic [1:0]        protect_sel_out,
  input wire logic              hw_protected_mode_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!resetn_in);
  int busy_cnt_q;
  always_ff @(posedge clk_sys_in or negedge resetn_in) begin
    if (!resetn_in) begin
      busy_cnt_q <= 0;
    end else begin
      busy_cnt_q <= write_busy_flag_out ? busy_cnt_q + 1 : 0;
    end
  end
  function automatic logic in_prot(input logic [10:0] a, input logic [1:0] s);
    return (s == SEL_WHOLE) || (s == SEL_HALF && a >= ADDR_HALF) ||
           (s == SEL_QUARTER && a >= ADDR_QUARTER);
  endfunction
  // ****************************************************************
  // Properties
  // ****************************************************************
  property p_busy_len;
    $fell(write_busy_flag_out) |-> busy_cnt_q == WRITE_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write cycle length wrong");
  property p_latch_end;
    $fell(write_busy_flag_out) |-> !write_latch_flag_out;
  endproperty
  a_latch_end: assert property (p_latch_end) else $error("latch kept after write");
  property p_sel_hold;
    !$stable(protect_sel_out) |-> $fell(write_busy_flag_out);
  endproperty
  a_sel_hold: assert property (p_sel_hold) else $error("protect bits moved early");
  property p_mem_resp;
    mem_wr_req_in |=> (mem_wr_accept_out != mem_wr_reject_out);
  endproperty
  a_mem_resp: assert property (p_mem_resp) else $error("no single answer");
  property p_mem_refuse;
    mem_wr_req_in && (!write_latch_flag_out || write_busy_flag_out ||
      in_prot(mem_wr_addr_in, protect_sel_out)) |=> mem_wr_reject_out;
  endproperty
  a_mem_refuse: assert property (p_mem_refuse) else $error("bad write accepted");
  property p_acc_busy;
    mem_wr_accept_out |-> ##[0:1] write_busy_flag_out;
  endproperty
  a_acc_busy: assert property (p_acc_busy) else $error("accept without busy");
  property p_hpm_exit;
    $rose(wp_n_in) |-> ##[1:5] !hw_protected_mode_out;
  endproperty
  a_hpm_exit: assert property (p_hpm_exit) else $error("protection not left");
  property p_hpm_hold;
    hw_protected_mode_out && !wp_n_in |=> hw_protected_mode_out;
  endproperty
  a_hpm_hold: assert property (p_hpm_hold) else $error("protection left early");
  property p_hpm_ro;
    hw_protected_mode_out |=> $stable(protect_sel_out);
  endproperty
  a_hpm_ro: assert property (p_hpm_ro) else $error("protect bits written");
  property p_oen_idle;
    spi_csn_in [*6] |-> spi_miso_oen_n_out;
  endproperty
  a_oen_idle: assert property (p_oen_idle) else $error("output driven idle");
  property p_latch_set;
    $rose(write_latch_flag_out) |-> spi_csn_in;
  endproperty
  a_latch_set: assert property (p_latch_set) else $error("latch set in frame");
endmodule
bind ssp_status_protect ssp_status_protect_checker #(.WRITE_CYCLES(WRITE_CYCLES))
  ssp_status_protect_checker_i (.clk_sys_in, .resetn_in, .spi_sck_in, .spi_csn_in,
  .spi_mosi_in, .spi_miso_out, .spi_miso_oen_n_out, .wp_n_in, .mem_wr_req_in,
  .mem_wr_addr_in, .mem_wr_accept_out, .mem_wr_reject_out, .write_latch_flag_out,
  .write_busy_flag_out, .protect_sel_out, .hw_protected_mode_out);

// ===== verification/ssp_status_protect_test.sv
/* Self-checking bench of ssp_status_protect: SPI host model, array
   write requests and write-protect pin. Assumes package compiled first. */
`timescale 1ns/1ps
module ssp_status_protect_test;
  import ssp_pkg::*;
  localparam int WCYC = 400;
  logic        clk_sys_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        wp_n = 1'b1;
  logic        req = 1'b0;
  logic [10:0] addr = '0;
  logic        sck, csn, mosi, miso, oen_n, acc, rej, latch, busy, hw_protected_mode;
  logic [1:0]  sel, exp_sel;
  logic [15:0] rd;
  logic [10:0] a;
  logic        exp_lock;
  logic [31:0] r;
  int          n_mismatch = 0;
  int          num_checks = 0;
  integer      seed = 5707;
  wire         miso_line = oen_n ? 1'b1 : miso;
  always #50 clk_sys_in = ~clk_sys_in;
  ssp_spi_host ssp_spi_host_i (.sck_out(sck), .csn_out(csn), .mosi_out(mosi), .miso_in(miso_line));
  ssp_status_protect #(.WRITE_CYCLES(WCYC)) ssp_status_protect_i (.clk_sys_in, .resetn_in,
    .spi_sck_in(sck), .spi_csn_in(csn), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oen_n_out(oen_n), .wp_n_in(wp_n), .mem_wr_req_in(req), .mem_wr_addr_in(addr),
    .mem_wr_accept_out(acc), .mem_wr_reject_out(rej), .write_latch_flag_out(latch),
    .write_busy_flag_out(busy), .protect_sel_out(sel), .hw_protected_mode_out(hw_protected_mode));
  // ****************************************************************
  // Expectations and checks
  // ****************************************************************
  function automatic logic [7:0] stat(input logic la, input logic bz);
    return {exp_lock, 3'b000, exp_sel, la, bz};
  endfunction
  function automatic logic prot(input logic [10:0] x, input logic [1:0] s);
    return (s == SEL_WHOLE) || (s == SEL_HALF && x >= ADDR_HALF) ||
           (s == SEL_QUARTER && x >= ADDR_QUARTER);
  endfunction
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic frame(input logic [23:0] bits, input int n);
    @(posedge clk_sys_in);
    #1 ssp_spi_host_i.xfer(bits, n, rd);
  endtask
  task automatic rd_stat(input string what, input logic la, input logic bz);
    frame({OP_READ_STATUS, 16'h0000}, 24);
    check(what, rd, {2{stat(la, bz)}});
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 600 && busy !== 1'b0; i++) @(posedge clk_sys_in);
    check("idle", busy, 1'b0);
  endtask
  task automatic mem_req(input logic [10:0] x, input logic ok);
    @(posedge clk_sys_in);
    #1 req = 1'b1;
    addr = x;
    @(posedge clk_sys_in);
    #1 req = 1'b0;
    check("mem answer", {acc, rej}, {ok, ~ok});
    if (ok) wait_idle();
  endtask
  task automatic set_stat(input logic [7:0] d, input logic ok);
    frame({OP_SET_LATCH, 16'h0000}, 8);
    check("latch set", latch, 1'b1);
    frame({OP_WRITE_STAT, d, 8'h00}, 16);
    if (ok) begin
      rd_stat("status busy", 1'b1, 1'b1);
      wait_idle();
      exp_lock = d[7];
      exp_sel = d[3:2];
    end
    check("after write", {latch, busy, sel}, {~ok, 1'b0, exp_sel});
    rd_stat("status", ~ok, 1'b0);
  endtask
  task automatic set_wp(input logic v, input logic exp_hpm);
    @(posedge clk_sys_in);
    #1 wp_n = v;
    repeat (6) @(posedge clk_sys_in);
    check("protected mode", hw_protected_mode, exp_hpm);
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    exp_lock = LOCK_RESET;
    exp_sel = SEL_RESET;
    repeat (8) @(posedge clk_sys_in);
    #1 resetn_in = 1'b1;
    repeat (3) @(posedge clk_sys_in);
    check("reset flags", {latch, busy, sel, hw_protected_mode}, 5'b00000);
    rd_stat("reset status", 1'b0, 1'b0);
    frame({OP_SET_LATCH, 16'h0000}, 8);
    frame({OP_CLEAR_LATCH, 16'h0000}, 8);
    check("latch clear", latch, 1'b0);
    frame({OP_WRITE_STAT, 8'h8C, 8'h00}, 16);
    check("no latch", {busy, sel}, 3'b000);
    mem_req(11'h000, 1'b0);
    $display("Test latch done");
    for (int s = 0; s < 4; s++) begin
      r = $random(seed);
      set_stat({1'b0, r[6:4], s[1:0], r[1:0]}, 1'b1);
      for (int k = 0; k < 3; k++) begin
        a = (k == 0) ? ADDR_HALF - 11'h001 : (k == 1) ? ADDR_QUARTER : r[26:16];
        frame({OP_SET_LATCH, 16'h0000}, 8);
        mem_req(a, !prot(a, exp_sel));
        check("latch after mem", latch, prot(a, exp_sel));
      end
    end
    $display("Test protect codes done");
    frame({OP_SET_LATCH, 16'h0000}, 8);
    frame({OP_WRITE_STAT, 8'h80, 8'h00}, 15);
    frame({OP_WRITE_STAT, 8'h80, 8'h00}, 17);
    check("bad boundary", {latch, busy, sel}, {2'b10, exp_sel});
    $display("Test boundary done");
    set_stat(8'h84, 1'b1);
    set_wp(1'b0, 1'b1);
    set_stat(8'h00, 1'b0);
    frame({OP_CLEAR_LATCH, 16'h0000}, 8);
    set_wp(1'b1, 1'b0);
    set_stat(8'h00, 1'b1);
    set_wp(1'b0, 1'b0);
    set_stat(8'h80, 1'b1);
    check("lock after pin", hw_protected_mode, 1'b1);
    set_wp(1'b1, 1'b0);
    set_stat(8'h00, 1'b1);
    $display("Test protected mode done");
    tally_and_finish();
  end
  initial begin
    #5000000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
